// ==== verilog/occ_pkg.sv ====
// Constants, field layout and state codes for the oscillator control block.
// Assumes one system clock, a synchronous active-high reset and a plain register port.
// Summary of operation
// - PLL output divider codes select 1..64, 256.
// - Fast RC divider codes same; default divide two.
// - Bit 22 reads one when secondary oscillator enabled and stable.
// - Bit 21 gates writes to peripheral divisor.
// - Peripheral clock is system clock over 1/2/4/8.
// - Bits 31-30, 23 and unused read zero.
// - Register writes need a preceding unlock sequence.
// - Configuration fields load from nonvolatile bits at reset.
`default_nettype none
package occ_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [3:0]  OFS_OSC_CONTROL = 4'h0;
  localparam logic [3:0]  OFS_UNLOCK      = 4'h4;
  localparam logic [31:0] UNLOCK_KEY1     = 32'haa996655;
  localparam logic [31:0] UNLOCK_KEY2     = 32'h556699aa;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int POS_PLL_ODIV  = 27;
  localparam int POS_FRC_DIV   = 24;
  localparam int POS_SOSC_RDY  = 22;
  localparam int POS_PB_RDY    = 21;
  localparam int POS_PB_DIV    = 19;
  localparam int POS_CUR_OSC   = 12;
  localparam int POS_NEW_OSC   = 8;
  localparam int POS_SOSC_EN   = 1;
  localparam int POS_OSW_REQ   = 0;

  // ---------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------
  localparam logic [2:0] RST_FRC_DIV   = 3'h1;
  localparam logic [1:0] RST_PB_DIV    = 2'h3;
  localparam logic [7:0] SWITCH_CYCLES = 8'h08;

  typedef enum logic [2:0] {
    OCC_IDLE   = 3'b001,
    OCC_SWITCH = 3'b010,
    OCC_DONE   = 3'b100
  } occ_state_e;

  // Division ratio exponent for a three-bit divider code.
  function automatic logic [3:0] occ_div_log2(input logic [2:0] code);
    occ_div_log2 = (code == 3'h7) ? 4'h8 : {1'b0, code};
  endfunction

endpackage
`default_nettype wire

// ==== verilog/occ_divider.sv ====
// Power-of-two clock-enable divider used for every divided clock.
// Assumes the source enable and log2 ratio are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module occ_divider
  import occ_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       src_tick,
  input  wire logic [3:0] ratio_log2,
  output logic            div_tick
);

  logic [7:0] count;
  logic [8:0] limit;

  // Terminal count is the ratio minus one; a ratio of one passes every tick.
  assign limit = 9'(9'h001 << ratio_log2) - 9'h001;

  // Count source ticks and pulse once per wrap.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      count    <= 8'h00;
      div_tick <= 1'b0;
    end
    else
    begin
      div_tick <= 1'b0;
      if (src_tick)
      begin
        if ({1'b0, count} >= limit)
        begin
          count    <= 8'h00;
          div_tick <= 1'b1;
        end
        else
        begin
          count <= count + 8'h01;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ==== verilog/occ_top.sv ====
// Oscillator control register with unlock, source switch and clock dividers.
// Assumes software drives one-cycle strobes and configuration bits are stable at reset.
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module occ_top
  import occ_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic [31:0]      reg_rdata,
  input  wire logic [2:0]  cfg_pll_output_divider,
  input  wire logic [1:0]  cfg_periph_bus_divider,
  input  wire logic [2:0]  cfg_new_osc_select,
  input  wire logic        cfg_secondary_osc_enable,
  input  wire logic        secondary_osc_stable,
  input  wire logic        pll_tick,
  input  wire logic        fast_rc_tick,
  output logic [2:0]       current_osc_select,
  output logic             pll_div_tick,
  output logic             fast_rc_div_tick,
  output logic             peripheral_bus_clock_tick,
  output logic             secondary_osc_enable
);

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [2:0] pll_output_divider;
  logic [2:0] fast_rc_divider;
  logic [1:0] periph_bus_divider;
  logic [2:0] new_osc_select;
  logic       osc_switch_request;
  logic       periph_div_write_ready;
  logic       secondary_osc_ready;
  logic [1:0] unlock_stage;
  logic       unlocked;
  logic       ctl_write;
  logic       key_write;
  logic [7:0] switch_count;
  occ_state_e state;
  occ_state_e next_state;

  // Control writes count only while the unlock window is open.
  assign ctl_write = reg_write && (reg_addr == OFS_OSC_CONTROL) && unlocked;
  assign key_write = reg_write && (reg_addr == OFS_UNLOCK);
  assign unlocked  = (unlock_stage == 2'h2);

  // ---------------------------------------------------------------
  // Unlock sequence
  // ---------------------------------------------------------------
  // Two keys in order open the register for one write; any other write relocks,
  // so a stray write cannot leave the clock tree exposed.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      unlock_stage <= 2'h0;
    end
    else if (ctl_write)
    begin
      unlock_stage <= 2'h0;
    end
    else if (key_write)
    begin
      if (unlock_stage == 2'h0 && reg_wdata == UNLOCK_KEY1)
      begin
        unlock_stage <= 2'h1;
      end
      else if (unlock_stage == 2'h1 && reg_wdata == UNLOCK_KEY2)
      begin
        unlock_stage <= 2'h2;
      end
      else
      begin
        unlock_stage <= 2'h0;
      end
    end
    else if (reg_write)
    begin
      unlock_stage <= 2'h0;
    end
  end

  // ---------------------------------------------------------------
  // Divider fields
  // ---------------------------------------------------------------
  // Configuration-derived fields take the strap inputs on reset.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pll_output_divider <= cfg_pll_output_divider;
      fast_rc_divider    <= RST_FRC_DIV;
      new_osc_select     <= cfg_new_osc_select;
      secondary_osc_enable <= cfg_secondary_osc_enable;
    end
    else if (ctl_write)
    begin
      pll_output_divider <= reg_wdata[POS_PLL_ODIV +: 3];
      fast_rc_divider    <= reg_wdata[POS_FRC_DIV +: 3];
      new_osc_select     <= reg_wdata[POS_NEW_OSC +: 3];
      secondary_osc_enable <= reg_wdata[POS_SOSC_EN];
    end
  end

  // The peripheral divisor changes only while its ready flag is up.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      periph_bus_divider <= cfg_periph_bus_divider;
    end
    else if (ctl_write && periph_div_write_ready)
    begin
      periph_bus_divider <= reg_wdata[POS_PB_DIV +: 2];
    end
  end

  // Ready drops for one cycle after a divisor change so the divider can settle.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      periph_div_write_ready <= 1'b1;
    end
    else
    begin
      periph_div_write_ready <= !(ctl_write && periph_div_write_ready);
    end
  end

  // Stable status is sampled only while the oscillator is enabled.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      secondary_osc_ready <= 1'b0;
    end
    else
    begin
      secondary_osc_ready <= secondary_osc_enable && secondary_osc_stable;
    end
  end

  // ---------------------------------------------------------------
  // Oscillator switch sequencer
  // ---------------------------------------------------------------
  // A request starts the dwell, which ends in a single update cycle.
  always_comb
  begin
    next_state = state;
    case (state)
      OCC_IDLE:
      begin
        if (osc_switch_request)
        begin
          next_state = OCC_SWITCH;
        end
      end
      OCC_SWITCH:
      begin
        if (switch_count == SWITCH_CYCLES)
        begin
          next_state = OCC_DONE;
        end
      end
      OCC_DONE:
      begin
        next_state = OCC_IDLE;
      end
      default:
      begin
        next_state = OCC_IDLE;
      end
    endcase
  end

  // Sequencer state register.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state <= OCC_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Dwell count covers the handover from the old clock to the new one.
  always_ff @(posedge clk)
  begin
    if (reset || state != OCC_SWITCH)
    begin
      switch_count <= 8'h00;
    end
    else
    begin
      switch_count <= switch_count + 8'h01;
    end
  end

  // Current source follows the new selection once the switch completes.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      current_osc_select <= cfg_new_osc_select;
    end
    else if (state == OCC_DONE)
    begin
      current_osc_select <= new_osc_select;
    end
  end

  // Software sets the request; hardware clears it at the end of a switch.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      osc_switch_request <= 1'b0;
    end
    else if (ctl_write && reg_wdata[POS_OSW_REQ])
    begin
      osc_switch_request <= 1'b1;
    end
    else if (state == OCC_DONE)
    begin
      osc_switch_request <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Clock dividers
  // ---------------------------------------------------------------
  // PLL output divider; code seven jumps to 256 rather than 128.
  occ_divider u_pll_div
  (
    .clk        (clk),
    .reset      (reset),
    .src_tick   (pll_tick),
    .ratio_log2 (occ_div_log2(pll_output_divider)),
    .div_tick   (pll_div_tick)
  );

  // Fast RC divider; reset leaves it dividing by two.
  occ_divider u_frc_div
  (
    .clk        (clk),
    .reset      (reset),
    .src_tick   (fast_rc_tick),
    .ratio_log2 (occ_div_log2(fast_rc_divider)),
    .div_tick   (fast_rc_div_tick)
  );

  // Peripheral bus clock as a tick every 1, 2, 4 or 8 system clocks.
  occ_divider u_pb_div
  (
    .clk        (clk),
    .reset      (reset),
    .src_tick   (1'b1),
    .ratio_log2 ({2'h0, periph_bus_divider}),
    .div_tick   (peripheral_bus_clock_tick)
  );

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  // Unmapped offsets and unimplemented bits read as zero.
  // Data stand for one cycle only, so a late sample sees zero, never stale data.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      reg_rdata <= 32'h00000000;
    end
    else if (reg_read && reg_addr == OFS_OSC_CONTROL)
    begin
      reg_rdata <= 32'h00000000;
      reg_rdata[POS_PLL_ODIV +: 3] <= pll_output_divider;
      reg_rdata[POS_FRC_DIV +: 3]  <= fast_rc_divider;
      reg_rdata[POS_SOSC_RDY]      <= secondary_osc_ready;
      reg_rdata[POS_PB_RDY]        <= periph_div_write_ready;
      reg_rdata[POS_PB_DIV +: 2]   <= periph_bus_divider;
      reg_rdata[POS_CUR_OSC +: 3]  <= current_osc_select;
      reg_rdata[POS_NEW_OSC +: 3]  <= new_osc_select;
      reg_rdata[POS_SOSC_EN]       <= secondary_osc_enable;
      reg_rdata[POS_OSW_REQ]       <= osc_switch_request;
    end
    else
    begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule
`default_nettype wire

// ==== bench/occ_props.sv ====
// Port checker for the oscillator control block.
// Assumes it is bound onto occ_top, which has one clock.
`timescale 1ns/1ps
`default_nettype none
module occ_props
  import occ_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic [2:0]  cfg_new_osc_select,
  input wire logic        cfg_secondary_osc_enable,
  input wire logic        secondary_osc_stable,
  input wire logic        pll_tick,
  input wire logic        fast_rc_tick,
  input wire logic [2:0]  current_osc_select,
  input wire logic        pll_div_tick,
  input wire logic        fast_rc_div_tick,
  input wire logic        secondary_osc_enable
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  logic key2_last;

  // Notes whether the latest write was the second key; gaps keep it.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      key2_last <= 1'b0;
    end
    else if (reg_write)
    begin
      key2_last <= reg_addr == OFS_UNLOCK && reg_wdata == UNLOCK_KEY2;
    end
  end

  sequence s_key(k);
    reg_write && reg_addr == OFS_UNLOCK && reg_wdata == k;
  endsequence
  sequence s_ctl;
    reg_write && reg_addr == OFS_OSC_CONTROL;
  endsequence
  property p_idle;
    !$past(reg_read) |-> reg_rdata == 32'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("read data outside slot");
  property p_unimpl;
    $past(reg_read) |-> (reg_rdata & 32'hc08788fc) == 32'h0;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unused bit set");
  property p_sosc;
    $past(reg_read) && reg_rdata[22] |-> $past(secondary_osc_stable, 2);
  endproperty
  a_sosc: assert property (p_sosc) else $error("ready while unstable");
  property p_pll;
    pll_div_tick |-> $past(pll_tick);
  endproperty
  a_pll: assert property (p_pll) else $error("pll tick uncaused");
  property p_frc;
    fast_rc_div_tick |-> $past(fast_rc_tick);
  endproperty
  a_frc: assert property (p_frc) else $error("fast rc tick uncaused");
  property p_rst;
    $fell(reset) |-> current_osc_select == cfg_new_osc_select
      && secondary_osc_enable == cfg_secondary_osc_enable;
  endproperty
  a_rst: assert property (p_rst) else $error("strap not loaded");
  property p_locked;
    s_ctl and !key2_last |=> $stable(secondary_osc_enable);
  endproperty
  a_locked: assert property (p_locked) else $error("locked write taken");
  property p_unlocked;
    s_key(UNLOCK_KEY1) ##1 s_key(UNLOCK_KEY2) ##1 s_ctl
      |=> secondary_osc_enable == $past(reg_wdata[1]);
  endproperty
  a_unlocked: assert property (p_unlocked) else $error("unlocked write lost");
endmodule

bind occ_top occ_props u_occ_props
(
  .clk                      (clk),
  .reset                    (reset),
  .reg_addr                 (reg_addr),
  .reg_wdata                (reg_wdata),
  .reg_write                (reg_write),
  .reg_read                 (reg_read),
  .reg_rdata                (reg_rdata),
  .cfg_new_osc_select       (cfg_new_osc_select),
  .cfg_secondary_osc_enable (cfg_secondary_osc_enable),
  .secondary_osc_stable     (secondary_osc_stable),
  .pll_tick                 (pll_tick),
  .fast_rc_tick             (fast_rc_tick),
  .current_osc_select       (current_osc_select),
  .pll_div_tick             (pll_div_tick),
  .fast_rc_div_tick         (fast_rc_div_tick),
  .secondary_osc_enable     (secondary_osc_enable)
);
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for the oscillator control block.
// Assumes occ_top and its bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import occ_pkg::*;
;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [2:0]  cfg_pll_output_divider = 3'h5;
  logic [1:0]  cfg_periph_bus_divider = 2'h2;
  logic [2:0]  cfg_new_osc_select = 3'h3;
  logic        cfg_secondary_osc_enable = 1'b1;
  logic        secondary_osc_stable = 1'b0;
  logic        pll_tick = 1'b1;
  logic        fast_rc_tick = 1'b0;
  logic [31:0] reg_rdata, rd_val;
  logic [2:0]  current_osc_select;
  logic        pll_div_tick, fast_rc_div_tick;
  logic        peripheral_bus_clock_tick, secondary_osc_enable;
  int          err_count = 0;
  int          comparisons = 0;
  // Divider code in bits 11:9 beside its ratio in bits 8:0.
  logic [11:0] rows [8] = '{12'h001, 12'h202, 12'h404, 12'h608,
                            12'h810, 12'ha20, 12'hc40, 12'hf00};

  occ_top u_occ_top
  (
    .clk                       (clk),
    .reset                     (reset),
    .reg_addr                  (reg_addr),
    .reg_wdata                 (reg_wdata),
    .reg_write                 (reg_write),
    .reg_read                  (reg_read),
    .reg_rdata                 (reg_rdata),
    .cfg_pll_output_divider    (cfg_pll_output_divider),
    .cfg_periph_bus_divider    (cfg_periph_bus_divider),
    .cfg_new_osc_select        (cfg_new_osc_select),
    .cfg_secondary_osc_enable  (cfg_secondary_osc_enable),
    .secondary_osc_stable      (secondary_osc_stable),
    .pll_tick                  (pll_tick),
    .fast_rc_tick              (fast_rc_tick),
    .current_osc_select        (current_osc_select),
    .pll_div_tick              (pll_div_tick),
    .fast_rc_div_tick          (fast_rc_div_tick),
    .peripheral_bus_clock_tick (peripheral_bus_clock_tick),
    .secondary_osc_enable      (secondary_osc_enable)
  );

  // ------------------------------------------------------------
  // Clock, sources and tasks
  // ------------------------------------------------------------
  // The fast RC source ticks every other cycle, doubling its period.
  always #25 clk = ~clk;
  always @(posedge clk) fast_rc_tick <= ~fast_rc_tick;

  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  // One strobe cycle, then one idle cycle; read data are taken at the edge
  // that closes the cycle in which they stand.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    reg_write <= w;
    reg_read <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
    reg_read <= 1'b0;
    @(posedge clk);
    rd_val = reg_rdata;
  endtask

  // Waits for divisor ready, then writes control behind both keys.
  task automatic ctl(input logic [31:0] d);
    for (int i = 0; i < 300; i++)
    begin
      bus(1'b0, OFS_OSC_CONTROL, 32'h0);
      if (rd_val[POS_PB_RDY] === 1'b1)
        break;
    end
    // Keys and control go back to back with the write strobe held high.
    reg_write <= 1'b1;
    reg_addr <= OFS_UNLOCK;
    reg_wdata <= UNLOCK_KEY1;
    @(posedge clk);
    reg_wdata <= UNLOCK_KEY2;
    @(posedge clk);
    reg_addr <= OFS_OSC_CONTROL;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic tk(input int s);
    return s == 0 ? pll_div_tick : s == 1 ? fast_rc_div_tick : peripheral_bus_clock_tick;
  endfunction

  // The third gap is taken, so a partial period after reprogramming is skipped.
  task automatic meas(input int s, input logic [31:0] e, input string n);
    int c;
    for (int k = 0; k < 3; k++)
    begin
      c = 0;
      do
      begin
        @(posedge clk);
        c++;
      end
      while (tk(s) !== 1'b1 && c < 600);
    end
    check(n, c, e);
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run of some 4000 cycles.
  initial
  begin
    #1500000;
    err_count++;
    conclude();
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial
  begin
    logic [2:0] d;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    foreach (rows[i])
    begin
      d = rows[i][11:9];
      ctl({2'h0, d, d, 3'h0, d[1:0], 8'h0, 3'h3, 8'h2});
      bus(1'b0, OFS_OSC_CONTROL, 32'h0);
      check("fields", rd_val & 32'h3f180000, {2'h0, d, d, 3'h0, d[1:0], 19'h0});
      meas(0, rows[i][8:0], "pll");
      meas(1, 2 * rows[i][8:0], "frc");
      meas(2, 32'h1 << d[1:0], "pb");
    end
    // A second reset in mid-run must reload every strapped field.
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    bus(1'b0, OFS_OSC_CONTROL, 32'h0);
    check("reset", rd_val, 32'h29303302);
    meas(0, 32'h20, "pll_rst");
    meas(1, 32'h4, "frc_rst");
    // A bare write and a key pair broken by another write are refused.
    bus(1'b1, OFS_OSC_CONTROL, 32'h0);
    bus(1'b1, OFS_UNLOCK, UNLOCK_KEY1);
    bus(1'b1, 4'h8, 32'h0);
    bus(1'b1, OFS_UNLOCK, UNLOCK_KEY2);
    bus(1'b1, OFS_OSC_CONTROL, 32'h0);
    bus(1'b0, OFS_OSC_CONTROL, 32'h0);
    check("locked", rd_val, 32'h29303302);
    bus(1'b0, 4'h8, 32'h0);
    check("unmapped", rd_val, 32'h0);
    // All ones reaches only writable fields and requests source 7.
    ctl(32'hffffffff);
    bus(1'b0, OFS_OSC_CONTROL, 32'h0);
    check("ones", rd_val & 32'hffdfffff, 32'h3f183703);
    for (int i = 0; i < 40 && current_osc_select !== 3'h7; i++)
      @(posedge clk);
    bus(1'b0, OFS_OSC_CONTROL, 32'h0);
    check("switch", rd_val & 32'h7001, 32'h7000);
    // Ready needs the oscillator both stable and enabled.
    secondary_osc_stable <= 1'b1;
    repeat (4) @(posedge clk);
    bus(1'b0, OFS_OSC_CONTROL, 32'h0);
    check("sosc_on", rd_val[22], 1'b1);
    ctl(32'h3f180700);
    bus(1'b0, OFS_OSC_CONTROL, 32'h0);
    check("sosc_off", {rd_val[22], secondary_osc_enable}, 2'h0);
    conclude();
  end
endmodule
`default_nettype wire
